// ===== src/ubf_pkg.sv
// How it works
// - Reset clears the receive error status register to zero.
// - Overrun keeps being flagged on each character until the receive buffer is read.
// - Receiver checks only the first stop bit, even with two selected.
// - Baud generator control is an 8-bit read/write byte, reset to zero.
// - Low nibble k from 0 to 14 divides the source clock by k plus 16.
// - High nibble picks main clock over 2^(n-1); 0000 is n=11, 0101..1110 n=1..10.
// - Main clock is the oscillator rate or half of it, per halving select.
// - Internal bit rate is main clock over 2^n over k plus 16.
// - External pin bit rate is pin rate over 2(k+16); prescaler ignored.
// - Frame: start, 7 or 8 bits, optional even/odd/zero parity, 1 or 2 stops.
// - 7-bit mode: transmit ignores bit 7, receive shows bit 7 as zero.
// - Error status records which kind of receive error occurred.
// - Internal generator selected releases the external baud clock pin for port use.
// - Even parity flags odd count of ones; odd parity flags even count.
// - Zero parity sends a zero bit and is never checked.
// - Status clears on buffer read or next character, unless that one has errors.
package ubf_pkg;

    // ==========================================================
    // Register addresses
    localparam logic [15:0] ADDR_MODE = 16'hFF70;
    localparam logic [15:0] ADDR_ERR  = 16'hFF71;
    localparam logic [15:0] ADDR_BRG  = 16'hFF73;
    localparam logic [15:0] ADDR_DATA = 16'hFF18;

    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_MODE = 8'h00;
    localparam logic [7:0] RST_ERR  = 8'h00;
    localparam logic [7:0] RST_BRG  = 8'h00;

    // ==========================================================
    // Mode register fields
    localparam int MODE_TXE  = 7;
    localparam int MODE_RXE  = 6;
    localparam int MODE_PS1  = 5;
    localparam int MODE_PS0  = 4;
    localparam int MODE_CL   = 3;
    localparam int MODE_STP  = 2;
    localparam int MODE_ISRM = 1;
    localparam int MODE_SCK  = 0;

    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD  = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;

    // ==========================================================
    // Error status fields
    localparam int ERR_PE  = 2;
    localparam int ERR_FE  = 1;
    localparam int ERR_OVE = 0;

    // ==========================================================
    // Baud generator constants
    localparam logic [4:0] K_BASE      = 5'h10;
    localparam logic [3:0] PRE_FIRST   = 4'h5;
    localparam logic [3:0] PRE_LAST    = 4'hE;
    localparam logic [3:0] PRE_OFFSET  = 4'h4;
    localparam logic [3:0] N_SLOWEST   = 4'hB;
    localparam logic [2:0] LAST_BIT_7  = 3'h6;
    localparam logic [2:0] LAST_BIT_8  = 3'h7;

    // ==========================================================
    // Transmit FIFO
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 8;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PARITY,
        ST_STOP
    } ubf_state_e;

endpackage : ubf_pkg

// ===== src/ubf_fifo.sv
`timescale 1ns/1ps
module ubf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [PW-1:0]    next_wr_ptr;
    logic [PW-1:0]    next_rd_ptr;
    logic [CW-1:0]    next_count;
    logic             next_in_ready;
    logic             push;
    logic             pop;

    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    // ==========================================================
    // Pointer and fill level
    always_comb begin
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count  = count;
        if (push) begin
            next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + PW'(1);
        end
        if (pop) begin
            next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + PW'(1);
        end
        if (push && !pop) begin
            next_count = count + CW'(1);
        end else if (pop && !push) begin
            next_count = count - CW'(1);
        end
        next_in_ready = (next_count != FULL);
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wr_ptr   <= '0;
            rd_ptr   <= '0;
            count    <= '0;
            in_ready <= 1'b1;
        end else begin
            wr_ptr   <= next_wr_ptr;
            rd_ptr   <= next_rd_ptr;
            count    <= next_count;
            in_ready <= next_in_ready;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : ubf_fifo

// ===== src/ubf_uart.sv
`timescale 1ns/1ps
module ubf_uart (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [7:0]  cpu_wdata,
    output logic [7:0]       cpu_rdata,
    output logic             tx_ready,
    input  wire logic        osc_halving_select,
    input  wire logic        ext_baud_clock_pin,
    output logic             ext_pin_port_release,
    input  wire logic        rxd,
    output logic             txd
);
    // ==========================================================
    // Register file state
    logic [7:0] async_mode_reg;
    logic [7:0] baud_gen_control;
    logic [7:0] rx_error_status_reg;
    logic [7:0] receive_buffer;
    logic       rx_unread;
    logic [7:0] next_async_mode_reg;
    logic [7:0] next_baud_gen_control;
    logic [7:0] next_rx_error_status_reg;
    logic [7:0] next_receive_buffer;
    logic       next_rx_unread;
    logic [7:0] next_cpu_rdata;
    logic       next_ext_pin_port_release;

    logic       txe;
    logic       rxe;
    logic [1:0] par_mode;
    logic       char8;
    logic       stop2;
    logic       sck_int;
    logic [3:0] divisor_k_field;
    logic [3:0] prescaler_select_field;
    logic [2:0] last_bit;

    assign txe      = async_mode_reg[ubf_pkg::MODE_TXE];
    assign rxe      = async_mode_reg[ubf_pkg::MODE_RXE];
    assign par_mode = async_mode_reg[ubf_pkg::MODE_PS1:ubf_pkg::MODE_PS0];
    assign char8    = async_mode_reg[ubf_pkg::MODE_CL];
    assign stop2    = async_mode_reg[ubf_pkg::MODE_STP];
    assign sck_int  = async_mode_reg[ubf_pkg::MODE_SCK];
    assign divisor_k_field        = baud_gen_control[3:0];
    assign prescaler_select_field = baud_gen_control[7:4];
    assign last_bit = char8 ? ubf_pkg::LAST_BIT_8 : ubf_pkg::LAST_BIT_7;

    // ==========================================================
    // Baud generator: prescaler and source select
    logic       fxx_phase;
    logic [9:0] pre_cnt;
    logic       ext_prev;
    logic       next_fxx_phase;
    logic [9:0] next_pre_cnt;
    logic       fxx_en;
    logic [3:0] n_val;
    logic [10:0] mask11;
    logic [9:0] pre_mask;
    logic       fsck_int;
    logic       fsck_ext;
    logic       fsck;
    logic [4:0] half_limit;

    always_comb begin
        // Main clock is the oscillator or its half
        fxx_en         = osc_halving_select | fxx_phase;
        next_fxx_phase = ~fxx_phase;
        next_pre_cnt   = fxx_en ? pre_cnt + 10'h001 : pre_cnt;
        if ((prescaler_select_field >= ubf_pkg::PRE_FIRST) &&
            (prescaler_select_field <= ubf_pkg::PRE_LAST)) begin
            n_val = prescaler_select_field - ubf_pkg::PRE_OFFSET;
        end else begin
            n_val = ubf_pkg::N_SLOWEST;
        end
        mask11   = (11'h001 << (n_val - 4'h1)) - 11'h001;
        pre_mask = mask11[9:0];
        fsck_int = fxx_en & ((pre_cnt & pre_mask) == pre_mask);
        fsck_ext = ext_baud_clock_pin & ~ext_prev;
        fsck     = sck_int ? fsck_int : fsck_ext;
        // Half bit lasts k+16 source ticks, a bit twice that
        half_limit = {1'b0, divisor_k_field} + ubf_pkg::K_BASE - 5'h01;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fxx_phase <= 1'b0;
            pre_cnt   <= '0;
            ext_prev  <= 1'b0;
        end else begin
            fxx_phase <= next_fxx_phase;
            pre_cnt   <= next_pre_cnt;
            ext_prev  <= ext_baud_clock_pin;
        end
    end

    // ==========================================================
    // Transmitter
    ubf_pkg::ubf_state_e tx_state;
    ubf_pkg::ubf_state_e next_tx_state;
    logic [4:0] tx_div;
    logic       tx_phase;
    logic [7:0] tx_shift;
    logic [2:0] tx_bit;
    logic       tx_par;
    logic       tx_second;
    logic       next_txd;
    logic [4:0] next_tx_div;
    logic       next_tx_phase;
    logic [7:0] next_tx_shift;
    logic [2:0] next_tx_bit;
    logic       next_tx_par;
    logic       next_tx_second;
    logic       tx_half;
    logic       tx_bit_end;
    logic       fifo_valid;
    logic       fifo_pop;
    logic [7:0] fifo_data;
    logic [7:0] tx_load;
    logic       fifo_push;

    always_comb begin
        next_tx_state  = tx_state;
        next_tx_div    = tx_div;
        next_tx_phase  = tx_phase;
        next_tx_shift  = tx_shift;
        next_tx_bit    = tx_bit;
        next_tx_par    = tx_par;
        next_tx_second = tx_second;
        next_txd       = txd;
        fifo_pop       = 1'b0;
        tx_load        = char8 ? fifo_data : {1'b0, fifo_data[6:0]};
        tx_half        = fsck && (tx_div == half_limit);
        tx_bit_end     = tx_half && tx_phase;
        if (fsck && (tx_state != ubf_pkg::ST_IDLE)) begin
            next_tx_div = tx_half ? 5'h00 : tx_div + 5'h01;
        end
        if (tx_half) begin
            next_tx_phase = ~tx_phase;
        end
        unique case (tx_state)
            ubf_pkg::ST_IDLE: begin
                next_txd = 1'b1;
                if (txe && fifo_valid) begin
                    fifo_pop      = 1'b1;
                    next_tx_shift = tx_load;
                    unique case (par_mode)
                        ubf_pkg::PAR_EVEN: next_tx_par = ^tx_load;
                        ubf_pkg::PAR_ODD:  next_tx_par = ~(^tx_load);
                        default:           next_tx_par = 1'b0;
                    endcase
                    next_tx_state  = ubf_pkg::ST_START;
                    next_txd       = 1'b0;
                    next_tx_div    = 5'h00;
                    next_tx_phase  = 1'b0;
                    next_tx_bit    = 3'h0;
                    next_tx_second = 1'b0;
                end
            end
            ubf_pkg::ST_START: begin
                if (tx_bit_end) begin
                    next_tx_state = ubf_pkg::ST_DATA;
                    next_txd      = tx_shift[0];
                end
            end
            ubf_pkg::ST_DATA: begin
                if (tx_bit_end) begin
                    next_tx_shift = {1'b0, tx_shift[7:1]};
                    next_tx_bit   = tx_bit + 3'h1;
                    next_txd      = tx_shift[1];
                    if (tx_bit == last_bit) begin
                        if (par_mode != ubf_pkg::PAR_NONE) begin
                            next_tx_state = ubf_pkg::ST_PARITY;
                            next_txd      = tx_par;
                        end else begin
                            next_tx_state = ubf_pkg::ST_STOP;
                            next_txd      = 1'b1;
                        end
                    end
                end
            end
            ubf_pkg::ST_PARITY: begin
                if (tx_bit_end) begin
                    next_tx_state = ubf_pkg::ST_STOP;
                    next_txd      = 1'b1;
                end
            end
            ubf_pkg::ST_STOP: begin
                if (tx_bit_end) begin
                    if (stop2 && !tx_second) begin
                        next_tx_second = 1'b1;
                    end else begin
                        next_tx_state = ubf_pkg::ST_IDLE;
                    end
                end
            end
        endcase
        if (!txe) begin
            next_tx_state = ubf_pkg::ST_IDLE;
            next_txd      = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_state  <= ubf_pkg::ST_IDLE;
            tx_div    <= '0;
            tx_phase  <= 1'b0;
            tx_shift  <= '0;
            tx_bit    <= '0;
            tx_par    <= 1'b0;
            tx_second <= 1'b0;
            txd       <= 1'b1;
        end else begin
            tx_state  <= next_tx_state;
            tx_div    <= next_tx_div;
            tx_phase  <= next_tx_phase;
            tx_shift  <= next_tx_shift;
            tx_bit    <= next_tx_bit;
            tx_par    <= next_tx_par;
            tx_second <= next_tx_second;
            txd       <= next_txd;
        end
    end

    assign fifo_push = cpu_wr && (cpu_addr == ubf_pkg::ADDR_DATA);

    ubf_fifo #(
        .WIDTH (ubf_pkg::FIFO_WIDTH),
        .DEPTH (ubf_pkg::FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (fifo_push),
        .in_ready  (tx_ready),
        .in_data   (cpu_wdata),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // ==========================================================
    // Receiver
    ubf_pkg::ubf_state_e rx_state;
    ubf_pkg::ubf_state_e next_rx_state;
    logic [4:0] rx_div;
    logic       rx_phase;
    logic [7:0] rx_shift;
    logic [2:0] rx_bit;
    logic       rx_par;
    logic [4:0] next_rx_div;
    logic       next_rx_phase;
    logic [7:0] next_rx_shift;
    logic [2:0] next_rx_bit;
    logic       next_rx_par;
    logic       rx_half;
    logic       rx_bit_end;
    logic       rx_done;
    logic [7:0] rx_data;
    logic       rx_pe;
    logic       rx_fe;

    always_comb begin
        next_rx_state = rx_state;
        next_rx_div   = rx_div;
        next_rx_phase = rx_phase;
        next_rx_shift = rx_shift;
        next_rx_bit   = rx_bit;
        next_rx_par   = rx_par;
        rx_done       = 1'b0;
        rx_fe         = 1'b0;
        rx_half       = fsck && (rx_div == half_limit);
        rx_bit_end    = rx_half && rx_phase;
        rx_data       = char8 ? rx_shift : {1'b0, rx_shift[7:1]};
        unique case (par_mode)
            ubf_pkg::PAR_EVEN: rx_pe = (^rx_shift) ^ rx_par;
            ubf_pkg::PAR_ODD:  rx_pe = ~((^rx_shift) ^ rx_par);
            default:           rx_pe = 1'b0;
        endcase
        if (fsck && (rx_state != ubf_pkg::ST_IDLE)) begin
            next_rx_div = rx_half ? 5'h00 : rx_div + 5'h01;
        end
        if (rx_half) begin
            next_rx_phase = ~rx_phase;
        end
        unique case (rx_state)
            ubf_pkg::ST_IDLE: begin
                if (!rxd) begin
                    next_rx_state = ubf_pkg::ST_START;
                    next_rx_div   = 5'h00;
                    next_rx_phase = 1'b0;
                end
            end
            ubf_pkg::ST_START: begin
                // Start bit confirmed at its middle, then counter restarts
                if (rx_half) begin
                    next_rx_state = rxd ? ubf_pkg::ST_IDLE : ubf_pkg::ST_DATA;
                    next_rx_div   = 5'h00;
                    next_rx_phase = 1'b0;
                    next_rx_shift = 8'h00;
                    next_rx_bit   = 3'h0;
                end
            end
            ubf_pkg::ST_DATA: begin
                if (rx_bit_end) begin
                    next_rx_shift = {rxd, rx_shift[7:1]};
                    next_rx_bit   = rx_bit + 3'h1;
                    if (rx_bit == last_bit) begin
                        next_rx_state = (par_mode != ubf_pkg::PAR_NONE) ?
                                        ubf_pkg::ST_PARITY : ubf_pkg::ST_STOP;
                    end
                end
            end
            ubf_pkg::ST_PARITY: begin
                if (rx_bit_end) begin
                    next_rx_par   = rxd;
                    next_rx_state = ubf_pkg::ST_STOP;
                end
            end
            ubf_pkg::ST_STOP: begin
                // Only the first stop bit is examined
                if (rx_bit_end) begin
                    rx_done       = 1'b1;
                    rx_fe         = ~rxd;
                    next_rx_state = ubf_pkg::ST_IDLE;
                end
            end
        endcase
        if (!rxe) begin
            next_rx_state = ubf_pkg::ST_IDLE;
            rx_done       = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rx_state <= ubf_pkg::ST_IDLE;
            rx_div   <= '0;
            rx_phase <= 1'b0;
            rx_shift <= '0;
            rx_bit   <= '0;
            rx_par   <= 1'b0;
        end else begin
            rx_state <= next_rx_state;
            rx_div   <= next_rx_div;
            rx_phase <= next_rx_phase;
            rx_shift <= next_rx_shift;
            rx_bit   <= next_rx_bit;
            rx_par   <= next_rx_par;
        end
    end

    // ==========================================================
    // Register access
    logic read_rx_buf;

    always_comb begin
        read_rx_buf              = cpu_rd && (cpu_addr == ubf_pkg::ADDR_DATA);
        next_async_mode_reg      = async_mode_reg;
        next_baud_gen_control    = baud_gen_control;
        next_rx_error_status_reg = rx_error_status_reg;
        next_receive_buffer      = receive_buffer;
        next_rx_unread           = rx_unread;
        if (cpu_wr && (cpu_addr == ubf_pkg::ADDR_MODE)) begin
            next_async_mode_reg = cpu_wdata;
        end
        if (cpu_wr && (cpu_addr == ubf_pkg::ADDR_BRG)) begin
            next_baud_gen_control = cpu_wdata;
        end
        // A completing character wins over a same-cycle buffer read
        if (rx_done) begin
            next_receive_buffer = rx_data;
            next_rx_unread      = 1'b1;
            next_rx_error_status_reg = 8'h00;
            next_rx_error_status_reg[ubf_pkg::ERR_PE]  = rx_pe;
            next_rx_error_status_reg[ubf_pkg::ERR_FE]  = rx_fe;
            next_rx_error_status_reg[ubf_pkg::ERR_OVE] = rx_unread & ~read_rx_buf;
        end else if (read_rx_buf) begin
            next_rx_unread           = 1'b0;
            next_rx_error_status_reg = 8'h00;
        end
        unique case (cpu_addr)
            ubf_pkg::ADDR_MODE: next_cpu_rdata = async_mode_reg;
            ubf_pkg::ADDR_ERR:  next_cpu_rdata = rx_error_status_reg;
            ubf_pkg::ADDR_BRG:  next_cpu_rdata = baud_gen_control;
            ubf_pkg::ADDR_DATA: next_cpu_rdata = receive_buffer;
            default:            next_cpu_rdata = 8'h00;
        endcase
        next_ext_pin_port_release = next_async_mode_reg[ubf_pkg::MODE_SCK];
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            async_mode_reg       <= ubf_pkg::RST_MODE;
            baud_gen_control     <= ubf_pkg::RST_BRG;
            rx_error_status_reg  <= ubf_pkg::RST_ERR;
            receive_buffer       <= 8'h00;
            rx_unread            <= 1'b0;
            cpu_rdata            <= 8'h00;
            ext_pin_port_release <= 1'b0;
        end else begin
            async_mode_reg       <= next_async_mode_reg;
            baud_gen_control     <= next_baud_gen_control;
            rx_error_status_reg  <= next_rx_error_status_reg;
            receive_buffer       <= next_receive_buffer;
            rx_unread            <= next_rx_unread;
            cpu_rdata            <= next_cpu_rdata;
            ext_pin_port_release <= next_ext_pin_port_release;
        end
    end

endmodule : ubf_uart

// ===== tb/ubf_uart_sva.sv
`timescale 1ns/1ps
module ubf_uart_sva (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_wr,
    input wire logic        cpu_rd,
    input wire logic [7:0]  cpu_wdata,
    input wire logic [7:0]  cpu_rdata,
    input wire logic        tx_ready,
    input wire logic        osc_halving_select,
    input wire logic        ext_baud_clock_pin,
    input wire logic        ext_pin_port_release,
    input wire logic        rxd,
    input wire logic        txd
);
    logic [7:0]  mode;
    logic [7:0]  brg;
    logic [16:0] low_cnt;
    int          n;
    int          fsck_c;
    int          bit_c;
    // ==========================================
    // Shadow registers and txd low-run length
    always_ff @(posedge clk) begin
        if (!nrst) begin
            mode <= 8'h00;
            brg  <= 8'h00;
        end else if (cpu_wr && cpu_addr == 16'hFF70) begin
            mode <= cpu_wdata;
        end else if (cpu_wr && cpu_addr == 16'hFF73) begin
            brg <= cpu_wdata;
        end
    end
    always_ff @(posedge clk) low_cnt <= (!nrst || txd) ? 17'h00000 : low_cnt + 17'h00001;
    always_comb begin
        n = (brg[7:4] >= 4'h5 && brg[7:4] <= 4'hE) ? int'(brg[7:4]) - 4 : 11;
        fsck_c = (osc_halving_select ? 1 : 2) << (n - 1);
        bit_c = 2 * (int'(brg[3:0]) + 16) * fsck_c;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_RST_ZERO: assert property (disable iff (1'b0) !nrst |=> cpu_rdata == 8'h00 && txd
        && tx_ready && !ext_pin_port_release) else $error("outputs not at reset values");
    AST_BRG_READBACK: assert property (cpu_wr && cpu_addr == 16'hFF73 ##1
        cpu_addr == 16'hFF73 && !cpu_wr |=> cpu_rdata == $past(cpu_wdata, 2))
        else $error("baud control readback wrong");
    AST_UNMAPPED: assert property (cpu_addr == 16'hFF72 |=> cpu_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_ERR_FIELD: assert property (cpu_addr == 16'hFF71 |=> cpu_rdata[7:3] == 5'h00)
        else $error("status upper bits set");
    AST_PIN_RELEASE: assert property (cpu_wr && cpu_addr == 16'hFF70 |-> ##2
        {7'h00, ext_pin_port_release} == ($past(cpu_wdata, 2) & 8'h01))
        else $error("pin release does not follow source select");
    AST_TX_OFF_IDLE: assert property (!mode[7] |=> txd)
        else $error("txd active with transmit off");
    AST_RUN_MIN: assert property ($rose(txd) && mode[7] && mode[0] |->
        int'(low_cnt) >= bit_c - fsck_c) else $error("txd low run shorter than a bit");
    AST_RUN_MAX: assert property (!txd && mode[7] && mode[0] |->
        int'(low_cnt) < 10 * bit_c) else $error("txd low run longer than a frame allows");
    cover property (cpu_wr && cpu_addr == 16'hFF73);
    cover property ($rose(txd) && mode[7]);
    cover property (cpu_addr == 16'hFF71 ##1 cpu_rdata[0]);
endmodule : ubf_uart_sva
bind ubf_uart ubf_uart_sva i_sva (.clk(clk), .nrst(nrst), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .tx_ready(tx_ready), .osc_halving_select(osc_halving_select),
    .ext_baud_clock_pin(ext_baud_clock_pin), .ext_pin_port_release(ext_pin_port_release),
    .rxd(rxd), .txd(txd));

// ===== tb/ubf_remote.sv
`timescale 1ns/1ps
module ubf_remote (
    input  wire logic clk,
    input  wire logic txd,
    output logic      rxd
);
    int bit_c = 32;
    initial rxd = 1'b1;
    // ==========================================
    // Start, eight bits LSB first, parity, stop; line idles high
    task automatic send(input logic [7:0] d, input logic par, input logic stp);
        logic [10:0] f;
        f = {stp, par, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            #1 rxd = f[i];
            repeat (bit_c - 1) @(posedge clk);
        end
        @(posedge clk);
        #1 rxd = 1'b1;
    endtask : send
    // Samples ten bits after the start bit, each in its middle
    task automatic grab(output logic [9:0] got);
        wait (txd === 1'b0);
        repeat (bit_c / 2) @(posedge clk);
        for (int i = 0; i < 10; i++) begin
            repeat (bit_c) @(posedge clk);
            got[i] = txd;
        end
    endtask : grab
endmodule : ubf_remote

// ===== tb/ubf_uart_tb.sv
`timescale 1ns/1ps
module ubf_uart_tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic        cpu_wr = 1'b0;
    logic        cpu_rd = 1'b0;
    logic [7:0]  cpu_wdata = 8'h00;
    logic [7:0]  cpu_rdata;
    logic        tx_ready;
    logic        osc = 1'b1;
    logic        ext_clk = 1'b0;
    logic        ext_rel;
    logic        rxd;
    logic        txd;
    logic [9:0]  got;
    logic [7:0]  d;
    int          bad_count = 0;
    int          check_count = 0;
    initial forever #12.5 clk = ~clk;
    initial #13.5 forever #100 ext_clk = ~ext_clk;
    ubf_uart i_dut (.clk(clk), .nrst(nrst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .tx_ready(tx_ready),
        .osc_halving_select(osc), .ext_baud_clock_pin(ext_clk),
        .ext_pin_port_release(ext_rel), .rxd(rxd), .txd(txd));
    ubf_remote i_far (.clk(clk), .txd(txd), .rxd(rxd));
    // ==========================================
    // Bus cycles and comparison
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] seen);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clk);
        #1 cpu_addr = a;
        cpu_wdata = v;
        cpu_wr = 1'b1;
        @(posedge clk);
        #1 cpu_wr = 1'b0;
    endtask : wr
    task automatic rd(input string what, input logic [15:0] a, input logic [9:0] exp);
        @(posedge clk);
        #1 cpu_addr = a;
        cpu_rd = 1'b1;
        @(posedge clk);
        #1 cpu_rd = 1'b0;
        chk(what, exp, {2'b00, cpu_rdata});
    endtask : rd
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out
    initial begin
        repeat (10) @(posedge clk);
        #1 nrst = 1'b1;
        rd("status", 16'hFF71, 10'h000);
        rd("brg", 16'hFF73, 10'h000);
        rd("hole", 16'hFF72, 10'h000);
        wr(16'hFF73, 8'h74);
        rd("brg", 16'hFF73, 10'h074);
        wr(16'hFF71, 8'h07);
        rd("status", 16'hFF71, 10'h000);
        // Fill the transmit queue with transmit off, one write too many
        wr(16'hFF73, 8'h50);
        wr(16'hFF70, 8'h39);
        for (int i = 0; i < 9; i++) wr(16'hFF18, 8'h05 + 8'h13 * 8'(i));
        chk("ready", 10'h000, {9'h000, tx_ready});
        chk("release", 10'h001, {9'h000, ext_rel});
        wr(16'hFF70, 8'hB9);
        for (int i = 0; i < 8; i++) begin
            d = 8'h05 + 8'h13 * 8'(i);
            i_far.grab(got);
            chk("frame", {1'b1, ^d, d}, got);
        end
        chk("ready", 10'h001, {9'h000, tx_ready});
        repeat (64) @(posedge clk);
        #1 osc = 1'b0;
        i_far.bit_c = 64;
        wr(16'hFF70, 8'h95);
        wr(16'hFF18, 8'hFF);
        i_far.grab(got);
        chk("frame7", 10'h37F, got);
        repeat (64) @(posedge clk);
        i_far.bit_c = 256;
        wr(16'hFF73, 8'hE0);
        wr(16'hFF70, 8'hB8);
        wr(16'hFF18, 8'h6A);
        chk("release", 10'h000, {9'h000, ext_rel});
        i_far.grab(got);
        chk("frame_ext", 10'h26A, got);
        repeat (256) @(posedge clk);
        #1 osc = 1'b1;
        i_far.bit_c = 32;
        wr(16'hFF73, 8'h50);
        wr(16'hFF70, 8'h6D);
        i_far.send(8'h3C, 1'b0, 1'b1);
        rd("status", 16'hFF71, 10'h004);
        rd("data", 16'hFF18, 10'h03C);
        rd("status", 16'hFF71, 10'h000);
        i_far.send(8'h81, 1'b1, 1'b1);
        i_far.send(8'h55, 1'b1, 1'b1);
        rd("status", 16'hFF71, 10'h001);
        i_far.send(8'h0F, 1'b1, 1'b0);
        rd("status", 16'hFF71, 10'h003);
        rd("data", 16'hFF18, 10'h00F);
        rd("status", 16'hFF71, 10'h000);
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        close_out();
    end
endmodule : ubf_uart_tb
